/* File: core/tla_defines.svh */
// constants of the temperature limit alarm: offsets, fields, resets
// assumes byte addressing on a 32-bit avalon-mm register port
`ifndef TLA_DEFINES_SVH
`define TLA_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TLA_OFS_CONFIG 8'h00
`define TLA_OFS_TEMP 8'h04
`define TLA_OFS_UPPER 8'h08
`define TLA_OFS_LOWER 8'h0C
`define TLA_OFS_CRIT 8'h10
`define TLA_OFS_HYST 8'h14
`define TLA_OFS_STATUS 8'h18
`define TLA_OFS_MASK 8'h1C
`define TLA_OFS_STATE 8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TLA_CFG_CMP_MODE 0
`define TLA_CFG_ACT_HIGH 1
`define TLA_CFG_SHUTDOWN 2
`define TLA_EVT_LIMIT 0
`define TLA_EVT_CRIT 1
`define TLA_ST_LIMIT_ACT 0
`define TLA_ST_CRIT_ACT 1
`define TLA_ST_LIMIT_OUT 2
`define TLA_ST_CRIT_OUT 3
`define TLA_ST_LIMIT_PIN 4
`define TLA_ST_CRIT_PIN 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TLA_CONFIG_RST 3'h0
`define TLA_UPPER_RST 16'h2000
`define TLA_LOWER_RST 16'h0280
`define TLA_CRIT_RST 16'h3000
`define TLA_HYST_RST 8'h05
`define TLA_MASK_RST 2'h0
`define TLA_NO_LOWER 16'h8000

`endif

/* File: core/tla_eval_if.sv */
// bundle between the alarm top and one limit evaluator
// assumes one clock domain; top drives limits, evaluator answers
interface tla_eval_if;
  import tla_pkg::*;

  tla_temp_t temp;
  tla_temp_t upper;
  tla_temp_t lower;
  logic [7:0] hyst;
  logic sample;
  logic read_clr;
  logic int_mode;
  logic asserted;
  logic out_limit;
  logic evt;

  modport eval
  (
    input temp, upper, lower, hyst, sample, read_clr, int_mode,
    output asserted, out_limit, evt
  );

  modport ctl
  (
    output temp, upper, lower, hyst, sample, read_clr, int_mode,
    input asserted, out_limit, evt
  );
endinterface

/* File: core/tla_limit_eval.sv */
// one limit evaluator: hysteresis zone tracker plus interrupt latch
// assumes samples arrive as one-cycle pulses on the same clock
module tla_limit_eval
  import tla_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  tla_eval_if.eval e
);
  tla_zone_t zone_q;
  tla_zone_t zone_d;
  logic latch_q;
  logic evt_q;

  // sign-extended threshold, raised or lowered by the hysteresis
  function automatic logic signed [16:0] thr(input tla_temp_t base,
                                             input logic [7:0] h,
                                             input logic up);
    logic signed [16:0] b;
    logic signed [16:0] d;
    b = {base[15], base};
    d = {9'h000, h};
    thr = up ? b + d : b - d;
  endfunction

  // ----------------------------------------------------------------
  // comparisons
  // ----------------------------------------------------------------
  wire logic signed [16:0] t_x = {e.temp[15], e.temp};
  wire logic over_up = t_x > thr(e.upper, 8'h00, 1'b1);
  wire logic under_lo = t_x < thr(e.lower, 8'h00, 1'b0);
  wire logic below_rel = t_x < thr(e.upper, e.hyst, 1'b0);
  wire logic above_rel = t_x > thr(e.lower, e.hyst, 1'b1);
  wire logic changed = e.sample && (zone_d != zone_q);

  // zone walk; leaving the high or low zone needs the hysteresis margin
  always_comb
  begin
    zone_d = zone_q;
    unique case (zone_q)
      TLA_IN:
      begin
        if (over_up) zone_d = TLA_HIGH;
        else if (under_lo) zone_d = TLA_LOW;
      end
      TLA_HIGH:
      begin
        if (below_rel) zone_d = under_lo ? TLA_LOW : TLA_IN;
      end
      TLA_LOW:
      begin
        if (above_rel) zone_d = over_up ? TLA_HIGH : TLA_IN;
      end
      default: zone_d = TLA_IN;
    endcase
  end

  // latch sets on every zone change; a set beats a same-cycle clear
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      zone_q <= TLA_IN;
      latch_q <= 1'b0;
      evt_q <= 1'b0;
    end
    else if (ce)
    begin
      evt_q <= changed;
      if (changed)
        zone_q <= zone_d;
      latch_q <= changed | (latch_q & ~e.read_clr);
    end
  end

  assign e.out_limit = zone_q != TLA_IN;
  assign e.asserted = e.int_mode ? latch_q : e.out_limit;
  assign e.evt = evt_q;
endmodule

/* File: core/tla_pin_sync.sv */
// three-stage synchroniser for a pin read back from outside
// assumes ref_clk domain; level accepted when stages two and three agree
module tla_pin_sync
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage is read only by the second
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level <= 1'b1;
    end
    else if (ce)
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level <= s3_q;
    end
  end
endmodule

/* File: core/tla_pkg.sv */
// types shared by the temperature limit alarm modules
// assumes nothing of its surroundings
package tla_pkg;

  // where the temperature stands against one pair of limits
  typedef enum logic [1:0] {
    TLA_IN,
    TLA_HIGH,
    TLA_LOW
  } tla_zone_t;

  typedef logic [15:0] tla_temp_t;

endpackage

/* File: core/tla_top.sv */
// temperature limit alarm: limit and critical open-drain alarm pins
// assumes an avalon-mm master on ref_clk and a converter that
// presents each new temperature with a one-cycle valid pulse
//
// Behaviour
// - limit and critical alarms run in comparator or latching interrupt mode.
// - after reset both alarms run in latching interrupt mode.
// - alarm asserts when temperature is above upper or below lower limit.
// - comparator mode releases past upper minus or lower plus hysteresis.
// - shutdown in comparator mode keeps the present alarm state.
// - interrupt mode holds the alarm until any register read clears it.
// - after clearing, only a change of zone (in, high or low) re-raises it.
// - cleared high event re-raises when below upper minus hysteresis.
// - re-armed alarm raises again as soon as a limit is exceeded anew.
`include "tla_defines.svh"

module tla_top
  import tla_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] temp_value,
  input wire logic temp_valid,
  input wire logic alarm_pin_in,
  output logic alarm_pin_out,
  output logic alarm_pin_oe_n,
  input wire logic critical_alarm_pin_in,
  output logic critical_alarm_pin_out,
  output logic critical_alarm_pin_oe_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [2:0] config_q;
  tla_temp_t temp_q;
  tla_temp_t upper_q;
  tla_temp_t lower_q;
  tla_temp_t crit_q;
  logic [7:0] hyst_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic sample_q;
  logic alarm_pin_level;
  logic crit_pin_level;

  tla_eval_if lim_if ();
  tla_eval_if crit_if ();

  // byte-lane merge of a 16-bit register with avalon write data
  function automatic tla_temp_t be_merge16(input tla_temp_t old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    be_merge16 = old;
    if (be[0]) be_merge16[7:0] = wd[7:0];
    if (be[1]) be_merge16[15:8] = wd[15:8];
  endfunction

  // open-drain enable: low means the pin is pulled low by us
  function automatic logic od_release(input logic active,
                                      input logic act_high);
    od_release = active ~^ act_high;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // a request is served on the single cycle waitrequest is low
  wire logic acc_take = (avs_read | avs_write) & avs_waitrequest;
  wire logic acc_done = ~avs_waitrequest;
  wire logic wr_en = avs_write & acc_done;
  wire logic rd_done = avs_read & acc_done;
  wire logic lane0 = avs_byteenable[0];

  wire logic sel_config = avs_address == `TLA_OFS_CONFIG;
  wire logic sel_upper = avs_address == `TLA_OFS_UPPER;
  wire logic sel_lower = avs_address == `TLA_OFS_LOWER;
  wire logic sel_crit = avs_address == `TLA_OFS_CRIT;
  wire logic sel_hyst = avs_address == `TLA_OFS_HYST;
  wire logic sel_status = avs_address == `TLA_OFS_STATUS;
  wire logic sel_mask = avs_address == `TLA_OFS_MASK;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire logic cmp_mode = config_q[`TLA_CFG_CMP_MODE];
  wire logic act_high = config_q[`TLA_CFG_ACT_HIGH];
  wire logic shutdown = config_q[`TLA_CFG_SHUTDOWN];

  // ----------------------------------------------------------------
  // status word and read mux
  // ----------------------------------------------------------------
  wire logic [1:0] evt_now = {crit_if.evt, lim_if.evt};
  wire logic [5:0] state_word = {
    crit_pin_level, alarm_pin_level,
    crit_if.out_limit, lim_if.out_limit,
    crit_if.asserted, lim_if.asserted
  };
  // unmapped offsets read as zero and ignore writes
  wire logic [31:0] rd_mux =
    (avs_address == `TLA_OFS_CONFIG) ? {29'h0000_0000, config_q} :
    (avs_address == `TLA_OFS_TEMP) ? {16'h0000, temp_q} :
    (avs_address == `TLA_OFS_UPPER) ? {16'h0000, upper_q} :
    (avs_address == `TLA_OFS_LOWER) ? {16'h0000, lower_q} :
    (avs_address == `TLA_OFS_CRIT) ? {16'h0000, crit_q} :
    (avs_address == `TLA_OFS_HYST) ? {24'h00_0000, hyst_q} :
    (avs_address == `TLA_OFS_STATUS) ? {30'h0000_0000, status_q} :
    (avs_address == `TLA_OFS_MASK) ? {30'h0000_0000, mask_q} :
    (avs_address == `TLA_OFS_STATE) ? {26'h000_0000, state_word} :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // avalon handshake
  // ----------------------------------------------------------------
  // fixed one wait cycle keeps the read mux off the output path
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      avs_waitrequest <= ~acc_take;
      if (acc_take && avs_read)
        avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  // reset value selects interrupt mode and active-low pins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      config_q <= `TLA_CONFIG_RST;
    else if (ce && wr_en && sel_config && lane0)
      config_q <= avs_writedata[2:0];
  end

  // ----------------------------------------------------------------
  // limit registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      upper_q <= `TLA_UPPER_RST;
      lower_q <= `TLA_LOWER_RST;
      crit_q <= `TLA_CRIT_RST;
      hyst_q <= `TLA_HYST_RST;
    end
    else if (ce && wr_en)
    begin
      if (sel_upper)
        upper_q <= be_merge16(upper_q, avs_writedata, avs_byteenable);
      if (sel_lower)
        lower_q <= be_merge16(lower_q, avs_writedata, avs_byteenable);
      if (sel_crit)
        crit_q <= be_merge16(crit_q, avs_writedata, avs_byteenable);
      if (sel_hyst && lane0)
        hyst_q <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // temperature capture
  // ----------------------------------------------------------------
  // shutdown stops new samples, so zones freeze; a read still clears the interrupt latches
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      temp_q <= 16'h0000;
      sample_q <= 1'b0;
    end
    else if (ce)
    begin
      sample_q <= temp_valid & ~shutdown;
      if (temp_valid && !shutdown)
        temp_q <= temp_value;
    end
  end

  // ----------------------------------------------------------------
  // evaluators
  // ----------------------------------------------------------------
  // both alarms share temperature, hysteresis, mode and read clear
  assign lim_if.temp = temp_q;
  assign lim_if.upper = upper_q;
  assign lim_if.lower = lower_q;
  assign lim_if.hyst = hyst_q;
  assign lim_if.sample = sample_q;
  assign lim_if.read_clr = rd_done;
  assign lim_if.int_mode = ~cmp_mode;

  // critical alarm has no lower limit: its floor is never undercut
  assign crit_if.temp = temp_q;
  assign crit_if.upper = crit_q;
  assign crit_if.lower = `TLA_NO_LOWER;
  assign crit_if.hyst = hyst_q;
  assign crit_if.sample = sample_q;
  assign crit_if.read_clr = rd_done;
  assign crit_if.int_mode = ~cmp_mode;

  tla_limit_eval u_lim_eval
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .e(lim_if.eval)
  );

  tla_limit_eval u_crit_eval
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .e(crit_if.eval)
  );

  // ----------------------------------------------------------------
  // pin read-back
  // ----------------------------------------------------------------
  // the wired pin may be held by another open-drain driver
  tla_pin_sync u_alarm_sync
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .pin(alarm_pin_in),
    .level(alarm_pin_level)
  );

  tla_pin_sync u_crit_sync
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .pin(critical_alarm_pin_in),
    .level(crit_pin_level)
  );

  // ----------------------------------------------------------------
  // open-drain alarm pins
  // ----------------------------------------------------------------
  // output data is a constant low; only the enable moves, and the
  // polarity bit flips meaning the same way in both modes
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      alarm_pin_out <= 1'b0;
      critical_alarm_pin_out <= 1'b0;
      alarm_pin_oe_n <= 1'b1;
      critical_alarm_pin_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      alarm_pin_out <= 1'b0;
      critical_alarm_pin_out <= 1'b0;
      alarm_pin_oe_n <= od_release(lim_if.asserted, act_high);
      critical_alarm_pin_oe_n <=
        od_release(crit_if.asserted, act_high);
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and output
  // ----------------------------------------------------------------
  // write one to clear; a new event in the same cycle stays set
  wire logic [1:0] st_clr =
    (wr_en && sel_status && lane0) ? avs_writedata[1:0] : 2'b00;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      status_q <= 2'b00;
      mask_q <= `TLA_MASK_RST;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      status_q <= evt_now | (status_q & ~st_clr);
      if (wr_en && sel_mask && lane0)
        mask_q <= avs_writedata[1:0];
      irq <= |(status_q & mask_q);
    end
  end

endmodule

/* File: tb/tla_host_model.sv */
// host side: pull-ups on both alarm wires, read by the host
// assumes the device only ever pulls the wires low
module tla_host_model
(
  input wire logic alarm_pin_oe_n,
  input wire logic critical_alarm_pin_oe_n,
  output logic alarm_level,
  output logic critical_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released wire rises to the pull-up level, never holds old data
  assign alarm_level = alarm_pin_oe_n ? 1'b1 : 1'b0;
  assign critical_level = critical_alarm_pin_oe_n ? 1'b1 : 1'b0;
endmodule

/* File: tb/tla_top_assertions.sv */
// checker for the alarm top, watching its ports only
// assumes ce stays high and a master that keeps the avalon rules
`include "tla_defines.svh"

module tla_top_assertions
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic temp_valid,
  input wire logic alarm_pin_out,
  input wire logic alarm_pin_oe_n,
  input wire logic critical_alarm_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cfg_q;
  // ----------
  // config shadow from completed writes
  // ----------
  wire logic done = ce && !avs_waitrequest;
  wire logic rd_done = done && avs_read;
  wire logic cfg_wr = done && avs_write && avs_byteenable[0]
    && avs_address == `TLA_OFS_CONFIG;
  // pin reads asserted when oe_n equals the active-high bit
  wire logic asrt = alarm_pin_oe_n == cfg_q[1];
  always_ff @(posedge ref_clk)
    if (reset)
      cfg_q <= `TLA_CONFIG_RST;
    else if (cfg_wr)
      cfg_q <= avs_writedata[2:0];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("request not answered after one wait cycle");
  property p_wait_pulse;
    !avs_waitrequest && ce |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low for more than one cycle");
  property p_od_data;
    !alarm_pin_out && !critical_alarm_pin_out;
  endproperty
  a_od_data: assert property (p_od_data)
    else $error("open-drain data not low");
  // hazard: a read clears the latch, pin follows one edge later
  property p_int_hold;
    !cfg_q[0] && asrt && !rd_done && !$past(rd_done) && !cfg_wr
      && !$past(cfg_wr) |=> asrt;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("latched alarm dropped without a read");
  property p_rd_clear;
    !cfg_q[0] && asrt && rd_done && !$past(temp_valid) |=> ##1 !asrt;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("read did not clear latched alarm");
  property p_no_spont;
    !cfg_q[0] && !asrt && !cfg_wr && !$past(cfg_wr) ##1 asrt
      |-> $past(temp_valid, 3);
  endproperty
  a_no_spont: assert property (p_no_spont)
    else $error("alarm raised without a sample");
  property p_shut_hold;
    cfg_q[0] && cfg_q[2] && !cfg_wr && !$past(cfg_wr)
      && !$past(cfg_wr, 2) |=> $stable(alarm_pin_oe_n);
  endproperty
  a_shut_hold: assert property (p_shut_hold)
    else $error("alarm changed in shutdown");
  property p_pol_flip;
    cfg_wr && avs_writedata[1] != cfg_q[1] && avs_writedata[0] == cfg_q[0]
      && !$past(temp_valid) && !$past(temp_valid, 2) && !$past(rd_done)
      |=> ##1 alarm_pin_oe_n != $past(alarm_pin_oe_n, 2);
  endproperty
  a_pol_flip: assert property (p_pol_flip)
    else $error("polarity change did not invert pin");
endmodule

bind tla_top tla_top_assertions i_tla_top_assertions (
  .ref_clk(ref_clk), .reset(reset), .ce(ce), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .temp_valid(temp_valid),
  .alarm_pin_out(alarm_pin_out), .alarm_pin_oe_n(alarm_pin_oe_n),
  .critical_alarm_pin_out(critical_alarm_pin_out));

/* File: tb/tla_top_tb.sv */
// self-checking bench for the alarm top and its host model
// assumes limits 100/20, hysteresis 5, integer temperature codes
`include "tla_defines.svh"

module tla_top_tb;
  import tla_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] RD = 16'h7FFF;
  localparam int UP = 100;
  localparam int LO = 20;
  localparam int HY = 5;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [15:0] temp_value = 16'h0000;
  logic temp_valid = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, alarm_pin_out, alarm_pin_oe_n, irq;
  logic crit_out, crit_oe_n, alarm_level, crit_level;
  logic act_q = 1'b0;
  logic crit_a = 1'b0;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  tla_zone_t zone;
  // scripted temperatures; RD stands for a register read
  logic [15:0] it [16] = '{16'h0065, RD, 16'h0062, 16'h005E, 16'h0032,
    RD, 16'h0065, RD, 16'h005E, RD, 16'h0013, RD, 16'h0018, 16'h001A,
    RD, 16'h001E};
  logic [0:15] ie = 16'b1001_1010_1010_0100;
  logic [15:0] ct [8] = '{16'h0065, 16'h0062, RD, 16'h005E, 16'h0013,
    16'h0018, 16'h001A, 16'h0065};
  logic [0:7] cx = 8'b1110_1101;

  always #20 ref_clk = ~ref_clk;

  tla_top i_tla_top (.ref_clk(ref_clk), .reset(reset), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .temp_value(temp_value),
    .temp_valid(temp_valid), .alarm_pin_in(alarm_level),
    .alarm_pin_out(alarm_pin_out), .alarm_pin_oe_n(alarm_pin_oe_n),
    .critical_alarm_pin_in(crit_level), .critical_alarm_pin_out(crit_out),
    .critical_alarm_pin_oe_n(crit_oe_n), .irq(irq));
  tla_host_model i_tla_host_model (.alarm_pin_oe_n(alarm_pin_oe_n),
    .critical_alarm_pin_oe_n(crit_oe_n), .alarm_level(alarm_level),
    .critical_level(crit_level));

  // ----------
  // reporting
  // ----------
  task automatic test_done();
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_reg(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    chk_reg(n, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  // runaway guard: far above the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      bad_count++;
      test_done();
    end
  end

  // ----------
  // drivers, all entered just after a rising edge
  // ----------
  // waits as long as it takes; only the runaway guard ends a hang
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // idle edge so the next request is not set in this time step
    @(posedge ref_clk);
  endtask
  task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk_reg(n, e, rd);
  endtask
  task automatic cfg(logic [2:0] v);
    bus(1'b1, `TLA_OFS_CONFIG, {29'h0000_0000, v});
    act_q = v[1];
  endtask
  task automatic temp(logic [15:0] t);
    temp_value <= t;
    temp_valid <= 1'b1;
    @(posedge ref_clk);
    temp_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  // one more edge lets the registered pin land
  task automatic pin(logic a);
    @(posedge ref_clk);
    chk_bit("alarm_pin_oe_n", ~(a ^ act_q), alarm_pin_oe_n);
    chk_bit("alarm_level", ~(a ^ act_q), alarm_level);
    chk_bit("critical_alarm_pin_oe_n", ~(crit_a ^ act_q), crit_oe_n);
  endtask
  task automatic step(logic [15:0] t, logic e);
    if (t == RD)
      rd_chk("unmapped", 8'h40, 32'h0000_0000);
    else
      temp(t);
    pin(e);
  endtask
  // zone the hysteresis tracker should reach after sample t
  function automatic tla_zone_t nz(tla_zone_t z, int t);
    case (z)
      TLA_HIGH: return (t >= UP - HY) ? TLA_HIGH :
        (t < LO) ? TLA_LOW : TLA_IN;
      TLA_LOW: return (t <= LO + HY) ? TLA_LOW :
        (t > UP) ? TLA_HIGH : TLA_IN;
      default: return (t > UP) ? TLA_HIGH : (t < LO) ? TLA_LOW : TLA_IN;
    endcase
  endfunction

  // ----------
  // main sequence
  // ----------
  initial
  begin
    void'($urandom(18));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd_chk("config", `TLA_OFS_CONFIG, 32'h0000_0000);
    rd_chk("temp", `TLA_OFS_TEMP, 32'h0000_0000);
    rd_chk("upper", `TLA_OFS_UPPER, 32'h0000_2000);
    rd_chk("lower", `TLA_OFS_LOWER, 32'h0000_0280);
    rd_chk("crit", `TLA_OFS_CRIT, 32'h0000_3000);
    rd_chk("hyst", `TLA_OFS_HYST, 32'h0000_0005);
    rd_chk("mask", `TLA_OFS_MASK, 32'h0000_0000);
    bus(1'b1, `TLA_OFS_UPPER, 32'h0000_0064);
    bus(1'b1, `TLA_OFS_LOWER, 32'h0000_0014);
    pin(1'b0);
    foreach (it[i]) step(it[i], ie[i]);
    cfg(3'h1);
    pin(1'b0);
    foreach (ct[i]) step(ct[i], cx[i]);
    cfg(3'h5);
    temp(16'h0032);
    pin(1'b1);
    cfg(3'h7);
    pin(1'b1);
    cfg(3'h3);
    temp(16'h0032);
    pin(1'b0);
    cfg(3'h2);
    step(RD, 1'b0);
    temp(16'h0065);
    pin(1'b1);
    cfg(3'h0);
    // status is sticky, mask gates the level output
    bus(1'b1, `TLA_OFS_STATUS, 32'h0000_0003);
    temp(16'h0032);
    pin(1'b1);
    chk_bit("irq", 1'b0, irq);
    rd_chk("status", `TLA_OFS_STATUS, 32'h0000_0001);
    bus(1'b1, `TLA_OFS_MASK, 32'h0000_0001);
    @(posedge ref_clk);
    chk_bit("irq", 1'b1, irq);
    bus(1'b1, `TLA_OFS_STATUS, 32'h0000_0001);
    @(posedge ref_clk);
    chk_bit("irq", 1'b0, irq);
    rd_chk("status", `TLA_OFS_STATUS, 32'h0000_0000);
    // random walk in comparator mode, direct high/low jumps included
    cfg(3'h1);
    zone = TLA_IN;
    repeat (40)
    begin
      int t;
      t = $urandom_range(120);
      zone = nz(zone, t);
      step(t[15:0], zone != TLA_IN);
    end
    // critical alarm trips, then both wired pins read back low
    bus(1'b1, `TLA_OFS_CRIT, 32'h0000_0078);
    crit_a = 1'b1;
    temp(16'h0079);
    pin(1'b1);
    // synchronisers need a few edges before the level is seen
    repeat (4) @(posedge ref_clk);
    rd_chk("state", `TLA_OFS_STATE, 32'h0000_000F);
    test_done();
  end
endmodule
